// *** pkg/clkbuf_pkg.sv ***
/*
 Constants, level codes and carriers for the clock buffer pin control block.
 Assumes pad comparators deliver each three-level pin as a two-bit code.
*/
package clkbuf_pkg;
  // three-level pin code from the pad comparator; 11 reads as open (mid)
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  // register indexes on the plain register port
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_STATE = 4'h2;
  // status and mask bit positions
  localparam int EV_LOCK_GAIN = 0;
  localparam int EV_LOCK_LOSS = 1;
  localparam int EV_REF_SWITCH = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
  // state register field positions
  localparam int ST_LOCK = 0;
  localparam int ST_TEST = 1;
  localparam int ST_REF_SEL = 2;
  localparam int ST_FB_SEL = 3;
  localparam int ST_PERIOD = 8;
  // phase steps span -8..+8 time units around the nominal tap
  localparam int PHASE_SPAN = 8;
  // bank 3 inversion patterns, bit order QA0 QA1 QB0 QB1 from bit 0
  localparam logic [3:0] INV_PAIRS = 4'hA;
  localparam logic [3:0] INV_ALL = 4'hF;
  localparam logic [3:0] INV_NONE = 4'h0;
  // one time unit for the reference model and the sys_clk period
  localparam int TU_NS = 100;
  localparam int CLK_NS = 100;
  localparam int TU_CYC = (TU_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    ACQUIRE = 2'b00,
    LOCKED = 2'b01
  } lock_state_t;

  // three-level strap pins, bank entries as {select1, select0}
  typedef struct packed {
    logic [1:0] freq_range;
    logic [1:0] fb_phase;
    logic [3:0] fb_div;
    logic [1:0] out_mode;
    logic [1:0] bank_three_invert;
    logic [3:0][3:0] bank_phase;
    logic [3:0][3:0] bank_div;
  } pin_levels_t;

  // clock output drive: level and enable per output
  typedef struct packed {
    logic [3:0][3:0] level;
    logic [3:0][3:0] enable;
    logic [1:0] fb_level;
    logic [1:0] fb_enable;
  } clk_drive_t;
endpackage : clkbuf_pkg

// *** src/pll_clock_buffer_pin_control.sv ***
/*
 Pin-controlled clock buffer: input selection, strap decode, bank phase,
 divide, disable, bank 3 inversion, lock and an event interrupt.
 Assumes reference and feedback clocks well below sys_clk / 4, and that
 the pads resolve three-level pins into two-bit codes.
*/
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module pll_clock_buffer_pin_control #(
  parameter int PW = 8,
  parameter int LOCK_COUNT = 4,
  parameter int LOCK_WIN = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reference_pair_first,
  input wire logic reference_pair_second,
  input wire logic reference_pair_select,
  input wire logic feedback_pair_first,
  input wire logic feedback_pair_second,
  input wire logic feedback_pair_select,
  input wire logic feedback_bank_disable,
  input wire logic [3:0] bank_output_disable,
  input wire clkbuf_pkg::pin_levels_t pins,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output clkbuf_pkg::clk_drive_t drive,
  output logic lock,
  output logic test_mode,
  output logic [15:0] reg_rdata,
  output logic irq
);
  import clkbuf_pkg::*;

  localparam int DL = 2 * PHASE_SPAN * TU_CYC + 1;
  // lock counter is four bits and the state word holds at most eight period bits
  if (PW < 3 || PW > 8 || LOCK_COUNT < 1 || LOCK_COUNT > 15 || LOCK_WIN < 0) begin : g_bad_param
    $error("unsupported parameter values");
  end

  // two-flop synchronisers for every pin
  logic [8:0] raw_in, s1, s2;
  pin_levels_t p1, p2;
  assign raw_in = {reference_pair_first, reference_pair_second, reference_pair_select,
                   feedback_pair_first, feedback_pair_second, feedback_pair_select,
                   feedback_bank_disable, bank_output_disable[3:2]};
  logic [1:0] dis1, dis2;
  always_ff @(posedge sys_clk) begin
    s1 <= raw_in;
    s2 <= s1;
    p1 <= pins;
    p2 <= p1;
    dis1 <= bank_output_disable[1:0];
    dis2 <= dis1;
  end

  // open pad code 11 is read as mid
  function automatic logic [1:0] lvl(input logic [1:0] c);
    lvl = (c == LVL_LOW || c == LVL_HIGH) ? c : LVL_MID;
  endfunction

  // input pair selection
  logic ref_sel, fb_sel, ref_clk, fb_clk, fb_dis;
  logic [3:0] bank_dis;
  assign ref_sel = s2[6];
  assign fb_sel = s2[3];
  assign ref_clk = ref_sel ? s2[7] : s2[8];
  assign fb_clk = fb_sel ? s2[4] : s2[5];
  assign fb_dis = s2[2];
  assign bank_dis = {s2[1:0], dis2};

  // mode decode from the output mode strap
  logic tst_mode, hiz_mode;
  assign tst_mode = lvl(p2.out_mode) == LVL_MID;
  assign hiz_mode = lvl(p2.out_mode) == LVL_HIGH;

  // edge detectors and switch tracking
  logic ref_q, fb_q, sel_q, ref_rise, fb_rise, switched;
  assign ref_rise = ref_clk & ~ref_q;
  assign fb_rise = fb_clk & ~fb_q;
  assign switched = ref_sel ^ sel_q;

  // period measure, base clock generator and lock state
  logic [PW-1:0] pcnt, period, cyc, since_fb;
  logic [PW-1:0] next_pcnt, next_period, next_cyc, next_since_fb;
  logic skip, next_skip;
  logic [3:0] good, next_good;
  lock_state_t lst, next_lst;
  logic base, base_rise;
  assign base = cyc < (period >> 1);
  assign base_rise = cyc == '0;

  always_comb begin
    next_pcnt = (pcnt == '1) ? pcnt : pcnt + 1'b1;
    next_period = period;
    next_skip = skip | switched;
    next_cyc = (cyc + 1'b1 >= period) ? '0 : cyc + 1'b1;
    next_since_fb = fb_rise ? '0 : ((since_fb == '1) ? since_fb : since_fb + 1'b1);
    next_good = good;
    next_lst = lst;
    if (ref_rise) begin
      next_pcnt = '0;
      next_cyc = '0;
      // partial period across a switch is never taken as the period
      if (skip || switched) begin
        next_skip = switched;
      end else if (pcnt + 1'b1 >= period || lst == ACQUIRE) begin
        next_period = pcnt + 1'b1;
      end
      if (fb_rise || since_fb <= PW'(LOCK_WIN)) begin
        next_good = (good == 4'(LOCK_COUNT)) ? good : good + 4'h1;
        if (good + 4'h1 >= 4'(LOCK_COUNT)) begin
          next_lst = LOCKED;
        end
      end else begin
        next_good = '0;
        next_lst = ACQUIRE;
      end
    end
    // a lost reference or a switch forces reacquisition
    if (pcnt == '1 || switched || tst_mode) begin
      next_good = '0;
      next_lst = ACQUIRE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ref_q <= 1'b0;
      fb_q <= 1'b0;
      sel_q <= 1'b0;
      pcnt <= '0;
      period <= '1;
      cyc <= '0;
      since_fb <= '1;
      skip <= 1'b1;
      good <= '0;
      lst <= ACQUIRE;
    end else begin
      ref_q <= ref_clk;
      fb_q <= fb_clk;
      sel_q <= ref_sel;
      pcnt <= next_pcnt;
      period <= next_period;
      cyc <= next_cyc;
      since_fb <= next_since_fb;
      skip <= next_skip;
      good <= next_good;
      lst <= next_lst;
    end
  end

  function automatic logic [3:0] ratio(input logic [3:0] c);
    case ({lvl(c[3:2]), lvl(c[1:0])})
      4'h0: ratio = 4'h1;
      4'h1: ratio = 4'h2;
      4'h2: ratio = 4'h3;
      4'h4: ratio = 4'h4;
      4'h5: ratio = 4'h5;
      4'h6: ratio = 4'h6;
      4'h8: ratio = 4'h8;
      4'h9: ratio = 4'hA;
      default: ratio = 4'hC;
    endcase
  endfunction

  // nine-step index of a phase select pair, 0..8
  function automatic int unsigned pidx(input logic [3:0] c);
    pidx = int'(lvl(c[3:2])) * 3 + int'(lvl(c[1:0]));
  endfunction

  // phase steps per bank, index 4 is the feedback bank
  logic signed [4:0] steps [5];
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      steps[b] = 5'(signed'(pidx(p2.bank_phase[b])) - 4);
    end
    for (int b = 2; b < 4; b++) begin
      case (pidx(p2.bank_phase[b]))
        3: steps[b] = steps[0];
        5: steps[b] = steps[1];
        default: steps[b] = 5'(2 * signed'(pidx(p2.bank_phase[b])) - 8 +
                   ((pidx(p2.bank_phase[b]) > 4) ? -2 : 2) * 0);
      endcase
      // outer entries sit at -8,-7,-6 and +6,+7,+8
      if (pidx(p2.bank_phase[b]) < 3) begin
        steps[b] = 5'(signed'(pidx(p2.bank_phase[b])) - 8);
      end else if (pidx(p2.bank_phase[b]) > 5) begin
        steps[b] = 5'(signed'(pidx(p2.bank_phase[b])));
      end else if (pidx(p2.bank_phase[b]) == 4) begin
        steps[b] = 5'sh0;
      end
    end
    case (lvl(p2.fb_phase))
      LVL_LOW: steps[4] = -5'sh4;
      LVL_HIGH: steps[4] = 5'sh4;
      default: steps[4] = 5'sh0;
    endcase
  end

  // bank 3 inversion pattern
  logic [3:0] inv_mask;
  always_comb begin
    case (lvl(p2.bank_three_invert))
      LVL_LOW: inv_mask = INV_PAIRS;
      LVL_HIGH: inv_mask = INV_ALL;
      default: inv_mask = INV_NONE;
    endcase
  end

  // per bank divider, phase delay line and output drive
  logic [4:0] bank_clk;
  logic [3:0] dcnt [5];
  logic [3:0] next_dcnt [5];
  logic [DL-1:0] dly [5];
  clk_drive_t next_drive;
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_bank
      logic [3:0] r;
      // bank_div has only four entries, so the feedback bank decodes its own pins
      if (g == 4) begin : g_fb
        assign r = ratio(p2.fb_div);
      end else begin : g_out
        assign r = ratio(p2.bank_div[g]);
      end
      always_comb begin
        next_dcnt[g] = dcnt[g];
        if (base_rise) begin
          next_dcnt[g] = (dcnt[g] + 4'h1 >= r) ? 4'h0 : dcnt[g] + 4'h1;
        end
      end
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          dcnt[g] <= '0;
          dly[g] <= '0;
        end else begin
          dcnt[g] <= next_dcnt[g];
          dly[g] <= {dly[g][DL-2:0], (r == 4'h1) ? base : (dcnt[g] < (r >> 1))};
        end
      end
      // tap moves by whole time units, nominal tap at mid line
      assign bank_clk[g] = dly[g][(int'(steps[g]) + PHASE_SPAN) * TU_CYC];
    end
  endgenerate

  // output drive: test bypass, disable styles and inversion
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      for (int o = 0; o < 4; o++) begin
        next_drive.level[b][o] = tst_mode ? ref_clk :
          (bank_clk[b] ^ (b == 2 && inv_mask[o])) & ~bank_dis[b];
        next_drive.enable[b][o] = ~(bank_dis[b] & hiz_mode);
      end
    end
    for (int o = 0; o < 2; o++) begin
      next_drive.fb_level[o] = tst_mode ? ref_clk : bank_clk[4] & ~fb_dis;
      next_drive.fb_enable[o] = ~(fb_dis & hiz_mode);
    end
  end

  // event flags, mask and register port
  logic [EV_W-1:0] status, mask, events, next_status, next_mask;
  logic [15:0] next_rdata;
  logic lock_now;
  assign lock_now = lst == LOCKED;
  assign events = {switched, lock & ~lock_now, ~lock & lock_now};
  always_comb begin
    next_mask = mask;
    next_status = status;
    if (reg_wr && reg_addr == REG_STATUS) begin
      next_status = status & ~reg_wdata[EV_W-1:0];
    end
    if (reg_wr && reg_addr == REG_MASK) begin
      next_mask = reg_wdata[EV_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    next_status = next_status | events;
    next_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: next_rdata[EV_W-1:0] = status;
        REG_MASK: next_rdata[EV_W-1:0] = mask;
        REG_STATE: next_rdata = {8'(period), 4'h0, fb_sel, ref_sel, test_mode, lock};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      status <= '0;
      mask <= MASK_RESET;
      reg_rdata <= '0;
      irq <= 1'b0;
      lock <= 1'b0;
      test_mode <= 1'b0;
      drive <= '0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      reg_rdata <= next_rdata;
      irq <= |(next_status & next_mask);
      lock <= lock_now;
      test_mode <= tst_mode;
      drive <= next_drive;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_ref_select;
    $rose(ref_sel) |-> ref_clk == s2[7];
  endproperty
  a_ref_select: assert property (p_ref_select) else $error("wrong reference pair");
  property p_fb_select;
    !fb_sel |-> fb_clk == s2[5];
  endproperty
  a_fb_select: assert property (p_fb_select) else $error("wrong feedback pair");
  property p_hiz;
    !tst_mode && hiz_mode && bank_dis[0] |=> !drive.enable[0][0];
  endproperty
  a_hiz: assert property (p_hiz) else $error("disabled bank still driven");
  property p_holdoff;
    !tst_mode && !hiz_mode && bank_dis[1] |=> drive.enable[1][3] && !drive.level[1][3];
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("hold-off not static low");
  property p_fb_dis;
    !tst_mode && fb_dis |=> !drive.fb_level[0] && !drive.fb_level[1];
  endproperty
  a_fb_dis: assert property (p_fb_dis) else $error("feedback bank not disabled");
  property p_inv_pair;
    !tst_mode && !bank_dis[2] && lvl(p2.bank_three_invert) == LVL_LOW
      |=> drive.level[2][0] != drive.level[2][1];
  endproperty
  a_inv_pair: assert property (p_inv_pair) else $error("bank 3 pair not complementary");
  property p_lock_switch;
    switched |=> ##1 !lock;
  endproperty
  a_lock_switch: assert property (p_lock_switch) else $error("lock held over switch");
  property p_test;
    tst_mode |=> test_mode && drive.fb_level[0] == $past(ref_clk);
  endproperty
  a_test: assert property (p_test) else $error("test mode not entered");
  property p_irq;
    events[EV_LOCK_GAIN] && mask[EV_LOCK_GAIN] |=> irq [*2];
  endproperty
  a_irq: assert property (p_irq) else $error("lock event lost");
endmodule : pll_clock_buffer_pin_control

// *** bench/board_model.sv ***
/*
 Board-side partner: two free-running reference oscillators and an ideal
 closed feedback path back to the feedback input pairs.
 Assumes the bench drives the select pins and commands the second path.
*/
`timescale 1ns/1ps
module board_model #(
  parameter int HALF_A = 400,
  parameter int HALF_B = 600
) (
  input wire logic ref_select,
  input wire logic fb_second_live,
  output logic ref_first,
  output logic ref_second,
  output logic fb_first,
  output logic fb_second
);
  // odd start offsets keep oscillator edges away from sys_clk edges
  initial begin
    ref_first = 1'b0;
    #37;
    forever #(HALF_A) ref_first = ~ref_first;
  end
  initial begin
    ref_second = 1'b0;
    #61;
    forever #(HALF_B) ref_second = ~ref_second;
  end
  // ideal loop: returned clock copies the selected reference
  assign fb_first = ref_select ? ref_second : ref_first;
  // dead second path sits at its pull-down level, not the last value
  assign fb_second = fb_second_live & fb_first;
endmodule : board_model

// *** bench/tb_top.sv ***
/*
 Self-checking bench for the clock buffer pin control block.
 Assumes the board partner model and the design package are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import clkbuf_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic ref_sel = 1'b0;
  logic fb_sel = 1'b0;
  logic fb_live = 1'b0;
  logic fb_dis = 1'b0;
  logic [3:0] bank_dis = 4'h0;
  pin_levels_t pins;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire logic ref_a, ref_b, fb_a, fb_b;
  clk_drive_t drive;
  logic lock, test_mode, irq;
  logic [15:0] reg_rdata;
  int n_fail = 0;
  int checked = 0;
  int i, c1, c2, cf;
  logic p1, p2, pf;
  logic [3:0] x;
  logic [1:0] inv_code [3] = '{LVL_LOW, LVL_HIGH, LVL_MID};
  logic [3:0] inv_pat [3] = '{INV_PAIRS, INV_ALL, INV_NONE};

  // 100 ns period
  always #50 sys_clk = ~sys_clk;

  pll_clock_buffer_pin_control pll_clock_buffer_pin_control_inst (
    .sys_clk(sys_clk), .reset(reset), .reference_pair_first(ref_a),
    .reference_pair_second(ref_b), .reference_pair_select(ref_sel),
    .feedback_pair_first(fb_a), .feedback_pair_second(fb_b),
    .feedback_pair_select(fb_sel), .feedback_bank_disable(fb_dis),
    .bank_output_disable(bank_dis), .pins(pins), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .drive(drive),
    .lock(lock), .test_mode(test_mode), .reg_rdata(reg_rdata), .irq(irq));

  board_model board_model_inst (
    .ref_select(ref_sel), .fb_second_live(fb_live), .ref_first(ref_a),
    .ref_second(ref_b), .fb_first(fb_a), .fb_second(fb_b));

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] ex, input string nm);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, ex, reg_rdata)
  endtask : rd
  // bounded wait, far beyond a lock count of reference edges
  task automatic wait_lock(input logic ex);
    for (int k = 0; k < 400 && lock !== ex; k++) tick(1);
    `CHK("lock", ex, lock)
  endtask : wait_lock
  task automatic give_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // watchdog: the sequence needs about a thousand cycles
  initial begin
    #(30000 * 100);
    n_fail++;
    give_verdict();
  end

  initial begin
    pins = '0;
    pins.freq_range = LVL_MID;
    pins.fb_phase = LVL_MID;
    pins.out_mode = LVL_LOW;
    pins.bank_three_invert = LVL_MID;
    pins.bank_phase = {4{4'h5}};
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rd(REG_MASK, 16'h0000, "mask reset");
    rd(REG_STATUS, 16'h0000, "status reset");
    wr(4'hF, 16'hFFFF);
    wr(REG_STATE, 16'hFFFF);
    rd(4'hF, 16'h0000, "unmapped");
    wait_lock(1'b1);
    rd(REG_STATUS, 16'h0001, "status gain");
    `CHK("irq masked", 1'b0, irq)
    wr(REG_MASK, 16'h0001);
    tick(3);
    `CHK("irq set", 1'b1, irq)
    wr(REG_STATUS, 16'h0001);
    tick(3);
    `CHK("irq clear", 1'b0, irq)
    rd(REG_STATE, 16'h0801, "state first ref");
    // switch to the slower second reference
    ref_sel <= 1'b1;
    wait_lock(1'b0);
    wait_lock(1'b1);
    rd(REG_STATUS, 16'h0007, "status switch");
    rd(REG_STATE, 16'h0C05, "state second ref");
    // second feedback pair dead: loop must not lock
    fb_sel <= 1'b1;
    wait_lock(1'b0);
    tick(200);
    `CHK("lock dead feedback", 1'b0, lock)
    fb_live <= 1'b1;
    wait_lock(1'b1);
    rd(REG_STATE, 16'h0C0D, "state second fb");
    // bank 1 /2, bank 2 /1, feedback bank /3
    pins.bank_div[0] <= 4'h1;
    pins.fb_div <= 4'h2;
    tick(20);
    c1 = 0;
    c2 = 0;
    cf = 0;
    repeat (240) begin
      p1 = drive.level[0][0];
      p2 = drive.level[1][0];
      pf = drive.fb_level[0];
      tick(1);
      if (drive.level[0][0] === 1'b1 && p1 === 1'b0) c1++;
      if (drive.level[1][0] === 1'b1 && p2 === 1'b0) c2++;
      if (drive.fb_level[0] === 1'b1 && pf === 1'b0) cf++;
    end
    `CHK("bank2 div1", 1'b1, c2 inside {[19:21]})
    `CHK("bank1 div2", 1'b1, (c1 * 2 - c2) inside {[-2:2]})
    `CHK("fb div3", 1'b1, (cf * 3 - c2) inside {[-3:3]})
    // bank 3 inversion codes against their patterns
    for (i = 0; i < 3; i++) begin
      pins.bank_three_invert <= inv_code[i];
      tick(8);
      repeat (16) begin
        x = drive.level[2] ^ inv_pat[i];
        `CHK("bank3 pattern", 1'b1, (x === 4'h0 || x === 4'hF))
        tick(1);
      end
    end
    // disable to high impedance, one bank at a time
    pins.out_mode <= LVL_HIGH;
    fb_dis <= 1'b1;
    for (i = 0; i < 4; i++) begin
      bank_dis <= 4'(4'h1 << i);
      tick(6);
      for (int b = 0; b < 4; b++)
        `CHK("bank enable", (b == i) ? 4'h0 : 4'hF, drive.enable[b])
    end
    `CHK("fb hiz", 2'h0, drive.fb_enable)
    // hold-off: driven and static low
    pins.out_mode <= LVL_LOW;
    bank_dis <= 4'hF;
    tick(6);
    repeat (20) begin
      `CHK("hold enable", 16'hFFFF, drive.enable)
      `CHK("hold level", 16'h0000, drive.level)
      `CHK("fb hold", 4'hC, {drive.fb_enable, drive.fb_level})
      tick(1);
    end
    fb_dis <= 1'b0;
    bank_dis <= 4'h0;
    c1 = 0;
    repeat (60) begin
      tick(1);
      if (drive.fb_level[0] === 1'b1) c1++;
    end
    `CHK("fb runs", 1'b1, c1 > 0)
    // test mode from mid and from open pin
    for (i = 0; i < 2; i++) begin
      pins.out_mode <= (i == 0) ? LVL_MID : 2'h3;
      tick(6);
      `CHK("test mode", 1'b1, test_mode)
      `CHK("lock in test", 1'b0, lock)
    end
    pins.out_mode <= LVL_LOW;
    wait_lock(1'b1);
    `CHK("test left", 1'b0, test_mode)
    give_verdict();
  end
endmodule : tb_top
